//--- tpm_regs.svh
`ifndef TPM_REGS_SVH
`define TPM_REGS_SVH

// register indices; the word byte address is four times the index
`define TPM_IDX_CTRL_A 14'h1FAE
`define TPM_IDX_CTRL_B 14'h1FAF
`define TPM_IDX_OUT 14'h1FB2
`define TPM_IDX_CNT 14'h1FB4
`define TPM_IDX_PERIOD 14'h1FB6
`define TPM_IDX_DUTY_U 14'h1FB8
`define TPM_IDX_DUTY_V 14'h1FBA
`define TPM_IDX_DUTY_W 14'h1FBC
`define TPM_IDX_DEAD 14'h1FBE
`define TPM_IDX_STAT 14'h1FD0
`define TPM_IDX_MASK 14'h1FD1

// pwm_control_a fields
`define TPM_A_EN 0
`define TPM_A_MODE 1
`define TPM_A_IDIV 3:2
`define TPM_A_LPOL 4
`define TPM_A_UPOL 5
`define TPM_A_DUTY 6
`define TPM_A_HALF 7

// phase_output_control fields
`define TPM_O_CTL 5:0
`define TPM_O_SRC 7:6
`define TPM_O_SEL 10:8
`define TPM_O_SYNC 11
`define TPM_O_PAT 14:12

// status and mask bits
`define TPM_ST_PWM 0
`define TPM_ST_UPD 1

// prescaler terminal counts for fc/2, fc/4, fc/8, fc/16
`define TPM_PRE_DIV2 4'h1
`define TPM_PRE_DIV4 4'h3
`define TPM_PRE_DIV8 4'h7
`define TPM_PRE_DIV16 4'hF

// period interrupt divider limits for 1, 2, 4, 8 periods
`define TPM_PDIV_1 3'h0
`define TPM_PDIV_2 3'h1
`define TPM_PDIV_4 3'h3
`define TPM_PDIV_8 3'h7

// dead time unit is 8 fc cycles: three zero bits below the count
`define TPM_DT_PAD 3'h0

`define TPM_RST_PERIOD 12'h010
`define TPM_RST_GATE 3'h7

`endif

//--- tpm_pkg.sv
package tpm_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } tpm_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tpm_apb_rsp_t;

    // index 0 is U, 1 is V, 2 is W
    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } tpm_gate_t;

    typedef enum logic [1:0] {TPM_DT_GAP, TPM_DT_HI, TPM_DT_LO} tpm_dt_state_t;

    typedef struct packed {
        tpm_dt_state_t st;
        logic [8:0] cnt;
        logic [8:0] gap;
        logic hi;
        logic lo;
    } tpm_dead_state_t;

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [1:0] clk_sel;
        logic [14:0] out_buf;
        logic [5:0] dead;
        logic [11:0] period;
        logic [2:0][11:0] duty;
        logic [11:0] period_act;
        logic [2:0][11:0] duty_act;
        logic [3:0] presc;
        logic [11:0] cnt;
        logic dir;
        logic [2:0] pdiv;
        logic pend;
        logic [5:0] act_ctl;
        logic [2:0] act_sel;
        logic [1:0] status;
        logic [1:0] mask;
        logic [31:0] prdata;
        logic pslverr;
        logic [2:0] gate_hi;
        logic [2:0] gate_lo;
    } tpm_state_t;

endpackage : tpm_pkg

//--- tpm_dead.sv
`timescale 1ns/1ps
`include "tpm_regs.svh"

module tpm_dead (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // waveform in, dead time count
    input wire logic pwm_in,
    input wire logic [5:0] dead,
    // switch requests
    output logic hi_on,
    output logic lo_on
);
    import tpm_pkg::*;

    tpm_dead_state_t s_q, s_d;
    localparam tpm_dead_state_t ST_RST = '{st: TPM_DT_GAP, default: '0};

    always_comb begin
        s_d = s_q;
        case (s_q.st)
            TPM_DT_GAP: begin
                if (s_q.cnt == 9'h000) begin
                    s_d.st = pwm_in ? TPM_DT_HI : TPM_DT_LO;
                end else begin
                    s_d.cnt = s_q.cnt - 9'h001;
                end
            end
            TPM_DT_HI: begin
                if (!pwm_in) begin
                    if (dead == 6'h00) begin
                        s_d.st = TPM_DT_LO;
                    end else begin
                        s_d.st = TPM_DT_GAP; // RQ8
                        s_d.cnt = {dead, `TPM_DT_PAD} - 9'h001; // RQ8
                    end
                end
            end
            TPM_DT_LO: begin
                if (pwm_in) begin
                    if (dead == 6'h00) begin
                        s_d.st = TPM_DT_HI;
                    end else begin
                        s_d.st = TPM_DT_GAP; // RQ8
                        s_d.cnt = {dead, `TPM_DT_PAD} - 9'h001; // RQ8
                    end
                end
            end
            default: begin
                s_d.st = TPM_DT_GAP;
            end
        endcase
        s_d.hi = (s_d.st == TPM_DT_HI);
        s_d.lo = (s_d.st == TPM_DT_LO);
        // gap length kept only for checking
        if (s_d.hi || s_d.lo) begin
            s_d.gap = 9'h000;
        end else if (s_q.gap != 9'h1FF) begin
            s_d.gap = s_q.gap + 9'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= ST_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign hi_on = s_q.hi;
    assign lo_on = s_q.lo;

    chk_dead_no_overlap: assert property ( // RQ8
        @(posedge pclk) disable iff (!presetn) !(s_q.hi && s_q.lo))
        else $error("upper and lower switch on together");

    chk_dead_gap_len: assert property ( // RQ8
        @(posedge pclk) disable iff (!presetn)
        ($rose(s_q.hi) || $rose(s_q.lo)) && $stable(dead) |->
        $past(s_q.gap) >= {dead, `TPM_DT_PAD})
        else $error("dead time gap shorter than programmed");

endmodule : tpm_dead

//--- tpm_pwm_top.sv
`timescale 1ns/1ps
`include "tpm_regs.svh"
// Overview of operation
// [RQ1] counter clock is fc over 2/4/8/16
// [RQ2] half-period interrupt when divider field is 00
// [RQ3] duty mode 0 shares U duty everywhere
// [RQ4] upper and lower polarity bits set active level
// [RQ5] interrupt every 1, 2, 4 or 8 periods
// [RQ6] mode 0 sawtooth, mode 1 up-down triangle
// [RQ7] outputs only while synthesis enable is set
// [RQ8] dead time is six-bit count times 8/fc
// [RQ9] readable direction bit, 1 while counting down
// [RQ10] writable three-bit position comparison pattern
// [RQ11] sync bit aligns output updates to period
// [RQ12] per-phase select: pwm or fixed level
// [RQ13] update source: now, position, timer 1, timer 2
// [RQ14] per-phase two control bits for fixed levels
// [RQ15] control writes buffered until sync event
// [RQ16] software keeps period at or above 010h
// [RQ17] counter compared with U, V, W duties

module tpm_pwm_top (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire tpm_pkg::tpm_apb_req_t apb_req,
    output tpm_pkg::tpm_apb_rsp_t apb_rsp,
    // update sync sources, one-cycle pulses
    input wire logic pos_det_evt,
    input wire logic tmr1_evt,
    input wire logic tmr2_evt,
    // gate drive and side outputs
    output tpm_pkg::tpm_gate_t gate,
    output logic [2:0] pos_pattern,
    output logic pwm_irq
);
    import tpm_pkg::*;

    localparam tpm_state_t ST_RST = '{
        gate_hi: `TPM_RST_GATE,
        gate_lo: `TPM_RST_GATE,
        period: `TPM_RST_PERIOD,
        period_act: `TPM_RST_PERIOD,
        default: '0
    };

    tpm_state_t s_q, s_d;
    logic en, tick, per_end, half_end, irq_evt, sync_go, apply;
    logic setup, wr, rd, hit;
    logic [13:0] idx;
    logic [31:0] rd_val;
    logic [3:0] pre_mask;
    logic [2:0] pdiv_lim;
    logic [2:0] hi_on, lo_on, gate_hi_d, gate_lo_d;

    assign en = s_q.ctrl_a[`TPM_A_EN];
    assign idx = apb_req.paddr[15:2];
    assign setup = apb_req.psel && !apb_req.penable;
    assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

    // address decode; read data is captured in the setup cycle
    always_comb begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (idx == `TPM_IDX_CTRL_A) begin
            rd_val = {24'h00_0000, s_q.ctrl_a};
        end else if (idx == `TPM_IDX_CTRL_B) begin
            rd_val = {30'h0000_0000, s_q.clk_sel};
        end else if (idx == `TPM_IDX_OUT) begin
            rd_val = {16'h0000, s_q.dir, s_q.out_buf}; // RQ9
        end else if (idx == `TPM_IDX_CNT) begin
            rd_val = {20'h0_0000, s_q.cnt};
        end else if (idx == `TPM_IDX_PERIOD) begin
            rd_val = {20'h0_0000, s_q.period};
        end else if (idx == `TPM_IDX_DUTY_U) begin
            rd_val = {20'h0_0000, s_q.duty[0]};
        end else if (idx == `TPM_IDX_DUTY_V) begin
            rd_val = {20'h0_0000, s_q.duty[1]};
        end else if (idx == `TPM_IDX_DUTY_W) begin
            rd_val = {20'h0_0000, s_q.duty[2]};
        end else if (idx == `TPM_IDX_DEAD) begin
            rd_val = {26'h000_0000, s_q.dead};
        end else if (idx == `TPM_IDX_STAT) begin
            rd_val = {30'h0000_0000, s_q.status};
        end else if (idx == `TPM_IDX_MASK) begin
            rd_val = {30'h0000_0000, s_q.mask};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        case (s_q.clk_sel)
            2'b00: pre_mask = `TPM_PRE_DIV2; // RQ1
            2'b01: pre_mask = `TPM_PRE_DIV4; // RQ1
            2'b10: pre_mask = `TPM_PRE_DIV8; // RQ1
            default: pre_mask = `TPM_PRE_DIV16; // RQ1
        endcase
        case (s_q.ctrl_a[`TPM_A_IDIV])
            2'b00: pdiv_lim = `TPM_PDIV_1; // RQ5
            2'b01: pdiv_lim = `TPM_PDIV_2; // RQ5
            2'b10: pdiv_lim = `TPM_PDIV_4; // RQ5
            default: pdiv_lim = `TPM_PDIV_8; // RQ5
        endcase
        case (s_q.out_buf[`TPM_O_SRC])
            2'b00: sync_go = s_q.out_buf[`TPM_O_SYNC] ? per_end : 1'b1; // RQ11
            2'b01: sync_go = pos_det_evt; // RQ13
            2'b10: sync_go = tmr1_evt; // RQ13
            default: sync_go = tmr2_evt; // RQ13
        endcase
    end

    assign tick = en && (s_q.presc == pre_mask); // RQ1

    // per-phase compare, dead time and output level
    for (genvar ph = 0; ph < 3; ph++) begin : g_phase
        logic [11:0] duty_sel;
        logic pwm_on, on_hi, on_lo;
        // common mode takes the U duty for every phase
        assign duty_sel = s_q.ctrl_a[`TPM_A_DUTY] ?
            s_q.duty_act[ph] : s_q.duty_act[0]; // RQ3
        assign pwm_on = (s_q.cnt < duty_sel); // RQ17
        tpm_dead u_tpm_dead (
            .pclk(pclk),
            .presetn(presetn),
            .clk_en(clk_en),
            .pwm_in(pwm_on),
            .dead(s_q.dead),
            .hi_on(hi_on[ph]),
            .lo_on(lo_on[ph])
        );
        assign on_hi = en && (s_q.act_sel[ph] ? hi_on[ph] :
            s_q.act_ctl[2*ph+1]); // RQ7 RQ12 RQ14
        assign on_lo = en && (s_q.act_sel[ph] ? lo_on[ph] :
            s_q.act_ctl[2*ph]); // RQ7 RQ12 RQ14
        assign gate_hi_d[ph] = s_q.ctrl_a[`TPM_A_UPOL] ? on_hi : !on_hi; // RQ4
        assign gate_lo_d[ph] = s_q.ctrl_a[`TPM_A_LPOL] ? on_lo : !on_lo; // RQ4
    end

    always_comb begin
        s_d = s_q;
        per_end = 1'b0;
        half_end = 1'b0;
        irq_evt = 1'b0;
        if (!en) begin
            // stopped counter restarts cleanly and reloads compares
            s_d.presc = 4'h0; // RQ7
            s_d.cnt = 12'h000; // RQ7
            s_d.dir = 1'b0;
            s_d.pdiv = 3'h0;
            s_d.period_act = s_q.period;
            s_d.duty_act = s_q.duty;
        end else begin
            s_d.presc = tick ? 4'h0 : s_q.presc + 4'h1; // RQ1
            if (tick && !s_q.ctrl_a[`TPM_A_MODE]) begin
                s_d.dir = 1'b0; // RQ6
                half_end = (s_q.cnt == {1'b0, s_q.period_act[11:1]});
                if (s_q.cnt >= s_q.period_act) begin
                    s_d.cnt = 12'h000; // RQ6
                    per_end = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end else if (tick && !s_q.dir) begin
                if (s_q.cnt >= s_q.period_act) begin
                    s_d.dir = 1'b1; // RQ6 RQ9
                    s_d.cnt = s_q.cnt - 12'h001;
                    half_end = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt + 12'h001;
                end
            end else if (tick) begin
                if (s_q.cnt == 12'h000) begin
                    s_d.dir = 1'b0; // RQ6 RQ9
                    s_d.cnt = 12'h001;
                    per_end = 1'b1;
                end else begin
                    s_d.cnt = s_q.cnt - 12'h001;
                end
            end
        end
        // while running, new period and duties only at the period boundary: no runt pulses
        if (per_end) begin
            s_d.period_act = s_q.period;
            s_d.duty_act = s_q.duty; // RQ17
            if (s_q.pdiv >= pdiv_lim) begin
                s_d.pdiv = 3'h0;
                irq_evt = 1'b1; // RQ5
            end else begin
                s_d.pdiv = s_q.pdiv + 3'h1;
            end
        end
        if (half_end && s_q.ctrl_a[`TPM_A_HALF] &&
            s_q.ctrl_a[`TPM_A_IDIV] == 2'b00) begin
            irq_evt = 1'b1; // RQ2
        end
        // buffered output control reaches the pins only on its event
        apply = s_q.pend && sync_go; // RQ15
        if (apply) begin
            s_d.act_ctl = s_q.out_buf[`TPM_O_CTL]; // RQ15
            s_d.act_sel = s_q.out_buf[`TPM_O_SEL]; // RQ15
            s_d.pend = 1'b0;
        end
        if (setup) begin
            s_d.prdata = hit ? rd_val : 32'h0000_0000;
            s_d.pslverr = !hit;
        end
        if (wr) begin
            if (idx == `TPM_IDX_CTRL_A) begin
                s_d.ctrl_a = apb_req.pwdata[7:0];
            end else if (idx == `TPM_IDX_CTRL_B) begin
                s_d.clk_sel = apb_req.pwdata[1:0];
            end else if (idx == `TPM_IDX_OUT) begin
                s_d.out_buf = apb_req.pwdata[14:0]; // RQ10 RQ15
                s_d.pend = 1'b1; // RQ15
            end else if (idx == `TPM_IDX_PERIOD) begin
                s_d.period = apb_req.pwdata[11:0];
            end else if (idx == `TPM_IDX_DUTY_U) begin
                s_d.duty[0] = apb_req.pwdata[11:0];
            end else if (idx == `TPM_IDX_DUTY_V) begin
                s_d.duty[1] = apb_req.pwdata[11:0];
            end else if (idx == `TPM_IDX_DUTY_W) begin
                s_d.duty[2] = apb_req.pwdata[11:0];
            end else if (idx == `TPM_IDX_DEAD) begin
                s_d.dead = apb_req.pwdata[5:0]; // RQ8
            end else if (idx == `TPM_IDX_MASK) begin
                s_d.mask = apb_req.pwdata[1:0];
            end
        end
        // read clears only the bits it returned, so an event landing in
        // the setup cycle is kept; an event in the access cycle still sets
        if (rd && idx == `TPM_IDX_STAT) begin
            s_d.status = s_q.status & ~s_q.prdata[1:0];
        end
        if (irq_evt) begin
            s_d.status[`TPM_ST_PWM] = 1'b1;
        end
        if (apply) begin
            s_d.status[`TPM_ST_UPD] = 1'b1;
        end
        s_d.gate_hi = gate_hi_d;
        s_d.gate_lo = gate_lo_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= ST_RST;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = s_q.pslverr;
    assign apb_rsp.prdata = s_q.prdata;
    assign gate.upper = s_q.gate_hi;
    assign gate.lower = s_q.gate_lo;
    assign pos_pattern = s_q.out_buf[`TPM_O_PAT]; // RQ10
    assign pwm_irq = |(s_q.status & s_q.mask);

    chk_cnt_prescale: assert property ( // RQ1
        @(posedge pclk) disable iff (!presetn)
        clk_en && en && !tick && s_d.ctrl_a[`TPM_A_EN] |=> $stable(s_q.cnt))
        else $error("counter moved without a prescaler tick");

    chk_half_irq: assert property ( // RQ2
        @(posedge pclk) disable iff (!presetn)
        clk_en && half_end && s_q.ctrl_a[`TPM_A_HALF] &&
        s_q.ctrl_a[`TPM_A_IDIV] == 2'b00 |=> s_q.status[`TPM_ST_PWM])
        else $error("half-period interrupt not raised");

    chk_duty_common: assert property ( // RQ3
        @(posedge pclk) disable iff (!presetn)
        !s_q.ctrl_a[`TPM_A_DUTY] |->
        g_phase[2].duty_sel == s_q.duty_act[0])
        else $error("common duty mode not using U duty");

    chk_gate_idle: assert property ( // RQ4
        @(posedge pclk) disable iff (!presetn)
        clk_en && !en |=> gate.upper == {3{!$past(s_q.ctrl_a[`TPM_A_UPOL])}}
        && gate.lower == {3{!$past(s_q.ctrl_a[`TPM_A_LPOL])}})
        else $error("disabled outputs not at inactive level");

    chk_irq_source: assert property ( // RQ5
        @(posedge pclk) disable iff (!presetn)
        $rose(s_q.status[`TPM_ST_PWM]) |-> $past(per_end || half_end))
        else $error("pwm interrupt without a period event");

    chk_saw_wrap: assert property ( // RQ6
        @(posedge pclk) disable iff (!presetn)
        clk_en && tick && !s_q.ctrl_a[`TPM_A_MODE] &&
        s_q.cnt >= s_q.period_act |=> s_q.cnt == 12'h000 && !s_q.dir)
        else $error("sawtooth did not wrap to zero");

    chk_tri_turn: assert property ( // RQ9
        @(posedge pclk) disable iff (!presetn)
        clk_en && tick && s_q.ctrl_a[`TPM_A_MODE] && !s_q.dir &&
        s_q.cnt >= s_q.period_act |=> s_q.dir ##1 !clk_en || s_q.dir ||
        !s_q.ctrl_a[`TPM_A_EN] || !s_q.ctrl_a[`TPM_A_MODE])
        else $error("triangle did not turn to counting down");

    chk_out_hold: assert property ( // RQ15
        @(posedge pclk) disable iff (!presetn)
        clk_en && s_q.pend && !sync_go |=> $stable(s_q.act_ctl) &&
        $stable(s_q.act_sel))
        else $error("output control changed before its sync event");

    // the checks below watch registered state one edge after its cause
    chk_tick_spacing: assert property ( // RQ1
        @(posedge pclk) disable iff (!presetn)
        clk_en && tick |=> !tick)
        else $error("prescaler ticked in consecutive cycles");

    chk_disable_hold: assert property ( // RQ7
        @(posedge pclk) disable iff (!presetn)
        clk_en && !en |=> s_q.cnt == 12'h000 && !s_q.dir)
        else $error("stopped counter not held at zero");

    chk_status_sticky: assert property ( // RQ5
        @(posedge pclk) disable iff (!presetn)
        clk_en && s_q.status[`TPM_ST_PWM] && !(rd && idx == `TPM_IDX_STAT)
        |=> s_q.status[`TPM_ST_PWM])
        else $error("pwm status bit lost without a read");

    chk_sync_period: assert property ( // RQ11
        @(posedge pclk) disable iff (!presetn)
        clk_en && s_q.pend && s_q.out_buf[`TPM_O_SRC] == 2'h0 &&
        s_q.out_buf[`TPM_O_SYNC] && !per_end |=> s_q.pend)
        else $error("synchronised update applied off the period end");

    chk_async_apply: assert property ( // RQ13
        @(posedge pclk) disable iff (!presetn)
        clk_en && s_q.pend && s_q.out_buf[`TPM_O_SRC] == 2'h0 &&
        !s_q.out_buf[`TPM_O_SYNC] && !wr |=> !s_q.pend)
        else $error("asynchronous output update left pending");

    chk_fixed_level: assert property ( // RQ12 RQ14
        @(posedge pclk) disable iff (!presetn)
        clk_en && en && !s_q.act_sel[0] && s_q.ctrl_a[`TPM_A_UPOL] |=>
        gate.upper[0] == $past(s_q.act_ctl[1]))
        else $error("fixed upper level not driven from control bits");

    chk_pend_set: assert property ( // RQ15
        @(posedge pclk) disable iff (!presetn)
        clk_en && wr && idx == `TPM_IDX_OUT |=> s_q.pend)
        else $error("output control write not held as pending");

endmodule : tpm_pwm_top

//--- tpm_gate_model.sv
`timescale 1ns/1ps

// stand-in for the inverter gate drivers: counts cycles in which
// both switches of one phase would conduct at once
module tpm_gate_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // gate pins and their active levels
    input wire tpm_pkg::tpm_gate_t gate,
    input wire logic upper_pol,
    input wire logic lower_pol,
    // shoot-through count
    output logic [15:0] overlap_cnt
);
    import tpm_pkg::*;
    logic [2:0] up_on;
    logic [2:0] lo_on;

    assign up_on = upper_pol ? gate.upper : ~gate.upper;
    assign lo_on = lower_pol ? gate.lower : ~gate.lower;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overlap_cnt <= 16'h0000;
        end else if ((up_on & lo_on) != 3'h0) begin
            overlap_cnt <= overlap_cnt + 16'h0001;
        end
    end
endmodule : tpm_gate_model

//--- tpm_pwm_top_tb.sv
`timescale 1ns/1ps
`include "tpm_regs.svh"

module tpm_pwm_top_tb;
    import tpm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    tpm_apb_req_t req = '0;
    tpm_apb_rsp_t rsp;
    logic pos_det_evt = 1'b0;
    logic tmr1_evt = 1'b0;
    logic tmr2_evt = 1'b0;
    tpm_gate_t gate;
    logic [2:0] pos_pattern;
    logic pwm_irq;
    logic [6:0] g;
    logic [6:0] gf;
    logic [7:0] ca = 8'h00;
    logic [15:0] overlap;
    logic [15:0] ov0;
    logic [31:0] rd;
    logic err;
    logic [1:0] seen;
    logic [5:0] c;
    logic [5:0] ge;
    logic [7:0] ia [5] = '{8'h33, 8'h37, 8'h3B, 8'h3F, 8'hB3};
    int ie [5] = '{128, 256, 512, 1024, 64};
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int d;
    int t1;
    int t2;
    int hits;

    always #4 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    assign g = {pwm_irq, gate};

    tpm_pwm_top u_tpm_pwm_top (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .apb_req(req), .apb_rsp(rsp),
        .pos_det_evt(pos_det_evt), .tmr1_evt(tmr1_evt),
        .tmr2_evt(tmr2_evt), .gate(gate), .pos_pattern(pos_pattern),
        .pwm_irq(pwm_irq));

    tpm_gate_model u_tpm_gate_model (.pclk(pclk), .presetn(presetn),
        .gate(gate), .upper_pol(ca[5]), .lower_pol(ca[4]),
        .overlap_cnt(overlap));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [13:0] idx,
            input logic [31:0] wd);
        @(posedge pclk);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= wd;
        @(posedge pclk);
        req.penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [13:0] idx, input logic [31:0] v);
        xfer(1'b1, idx, v);
    endtask : wr

    task automatic rdchk(input logic [13:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0);
        chk(rd, e);
    endtask : rdchk

    // polarity seen by the gate model follows only after the write lands
    task automatic seta(input logic [7:0] v);
        wr(`TPM_IDX_CTRL_A, {24'h0, v});
        ca = v;
    endtask : seta

    task automatic wait_bit(input int b, input logic v, output int t);
        int k;
        k = 0;
        while (g[b] !== v && k < 4000) begin
            @(posedge pclk);
            k++;
        end
        t = cyc;
        if (k >= 4000) begin
            chk(32'h0, 32'h1);
        end
    endtask : wait_bit

    task automatic per(input int b, output int dd);
        int t;
        int ta;
        wait_bit(b, 1'b0, t);
        wait_bit(b, 1'b1, ta);
        wait_bit(b, 1'b0, t);
        wait_bit(b, 1'b1, t);
        dd = t - ta;
    endtask : per

    task automatic irq_gap(output int dd);
        int ta;
        int tb;
        ta = 0;
        repeat (3) begin
            wait_bit(6, 1'b1, tb);
            xfer(1'b0, `TPM_IDX_STAT, 32'h0);
            @(posedge pclk);
            dd = tb - ta;
            ta = tb;
        end
    endtask : irq_gap

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(g[5:0], 6'h3F);
        rdchk(`TPM_IDX_CTRL_A, 32'h0);
        rdchk(`TPM_IDX_PERIOD, 32'h010);
        xfer(1'b0, 14'h0100, 32'h0);
        chk(err, 1'b1);
        wr(`TPM_IDX_OUT, 32'h5000);
        repeat (3) @(posedge pclk);
        chk(pos_pattern, 3'b101);
        seta(8'h30);
        repeat (5) @(posedge pclk);
        ov0 = overlap;
        wr(`TPM_IDX_PERIOD, 32'h20);
        wr(`TPM_IDX_DUTY_U, 32'h10);
        wr(`TPM_IDX_OUT, 32'h100);
        seta(8'h31);
        for (int s = 0; s < 4; s++) begin
            wr(`TPM_IDX_CTRL_B, 32'(s));
            per(3, d);
            per(3, d);
            chk(d, 33 * (2 << s));
        end
        wr(`TPM_IDX_CTRL_B, 32'h0);
        seta(8'h33);
        per(3, d);
        per(3, d);
        chk(d, 128);
        // with clock enable low no pin may move for a whole period
        @(posedge pclk);
        clk_en <= 1'b0;
        @(posedge pclk);
        gf = g;
        hits = 0;
        repeat (130) begin
            @(posedge pclk);
            if (g !== gf) hits++;
        end
        clk_en <= 1'b1;
        chk(hits, 32'h0);
        seen = 2'b00;
        repeat (50) begin
            xfer(1'b0, `TPM_IDX_OUT, 32'h0);
            if (rd[15] === 1'b1) seen[1] = 1'b1;
            if (rd[15] === 1'b0) seen[0] = 1'b1;
        end
        chk(seen, 2'b11);
        wr(`TPM_IDX_DEAD, 32'h3);
        per(3, d);
        wait_bit(0, 1'b1, t1);
        wait_bit(0, 1'b0, t1);
        wait_bit(3, 1'b1, t2);
        chk(t2 - t1, 24);
        wr(`TPM_IDX_DEAD, 32'h0);
        wr(`TPM_IDX_OUT, 32'h700);
        for (int m = 0; m < 2; m++) begin
            seta(m ? 8'h73 : 8'h33);
            repeat (130) @(posedge pclk);
            hits = 0;
            repeat (256) begin
                @(posedge pclk);
                if (g[4] === 1'b1) hits++;
            end
            chk(hits != 0, m == 0);
        end
        wr(`TPM_IDX_MASK, 32'h1);
        for (int p = 0; p < 5; p++) begin
            seta(ia[p]);
            irq_gap(d);
            chk(d, ie[p]);
            chk(rd[0], 1'b1);
        end
        wr(`TPM_IDX_MASK, 32'h2);
        seta(8'h31);
        wr(`TPM_IDX_OUT, 32'h0);
        repeat (4) @(posedge pclk);
        chk(g[5:0], 6'h00);
        ge = 6'h00;
        for (int s = 1; s < 4; s++) begin
            c = (s == 2) ? 6'h01 : 6'h02;
            wr(`TPM_IDX_OUT, {24'h0, s[1:0], c});
            // drop the update flag left by earlier writes
            xfer(1'b0, `TPM_IDX_STAT, 32'h0);
            repeat (3) @(posedge pclk);
            chk(g[5:0], ge);
            @(posedge pclk);
            pos_det_evt <= (s == 1);
            tmr1_evt <= (s == 2);
            tmr2_evt <= (s == 3);
            @(posedge pclk);
            {pos_det_evt, tmr1_evt, tmr2_evt} <= 3'b000;
            repeat (4) @(posedge pclk);
            ge = {2'b00, c[1], 2'b00, c[0]};
            chk(g[5:0], ge);
            xfer(1'b0, `TPM_IDX_STAT, 32'h0);
            chk(rd[1], 1'b1);
        end
        wr(`TPM_IDX_OUT, 32'h801);
        repeat (150) @(posedge pclk);
        chk(g[5:0], 6'h01);
        seta(8'h30);
        repeat (4) @(posedge pclk);
        chk(g[5:0], 6'h00);
        rdchk(`TPM_IDX_CNT, 32'h0);
        chk(overlap, ov0);
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        end_sim();
    end
endmodule : tpm_pwm_top_tb
